// [common/tbr_map.svh]
// Purpose: register offsets, field positions and reset values of the touch button readout bank
// Assumes: byte-wide register space, one byte per offset
// Notes:   result pairs sit high byte first
`ifndef TBR_MAP_SVH
`define TBR_MAP_SVH

`define TBR_OFS_LOCK        8'h79
`define TBR_OFS_ADDR_DRIVE  8'h7C
`define TBR_OFS_SELECT      8'h81
`define TBR_OFS_BASE_HI     8'h82
`define TBR_OFS_BASE_LO     8'h83
`define TBR_OFS_DIFF_HI     8'h84
`define TBR_OFS_DIFF_LO     8'h85
`define TBR_OFS_RAW_HI      8'h86
`define TBR_OFS_RAW_LO      8'h87
`define TBR_OFS_STATUS      8'h88

`define TBR_BIT_PULLUP_DIS  7
`define TBR_BIT_READ_EN     7
`define TBR_RST_SLAVE_ADDR  7'h00
`define TBR_RST_PULLUP_DIS  1'h0
`define TBR_RST_SEL_MASK    2'h0
`define TBR_RST_READ_EN     1'h0
`define TBR_RST_STATUS      2'h0

`endif

// [common/tbr_pkg.sv]
// Purpose: types shared by the touch button readout bank
// Assumes: two touch inputs
// Notes:   none
package tbr_pkg;

  typedef struct packed {
    logic [15:0] baseline_value;
    logic [15:0] difference_count;
    logic [15:0] raw_count;
  } tbr_result_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tbr_req_t;

endpackage

// [rtl/tbr_regs.sv]
// Purpose: address/drive, readout select, scan result and sensor status registers of a touch controller
// Assumes: the bus engine, lock register and sensing core run on I_CLOCK
// Notes:   register access is one request per cycle; read data returns one cycle later
//
// How it works
// [RULE1] Host unlocks before writing address; locked writes ignored
// [RULE2] New address and drive apply on relock
// [RULE3] Bit 7 one disables internal pull-ups
// [RULE4] Bits 6:0 hold the bus slave address
// [RULE5] Results shown for one selected input only
// [RULE6] Selecting a non-touch pin keeps old selection
// [RULE7] Bit 7 of select enables result reading
// [RULE8] Select mask must be one-hot, else discarded
// [RULE9] Mask 01 picks button 1, 10 button 2
// [RULE10] Baseline pair reads high byte then low
// [RULE11] Difference pair reads high byte then low
// [RULE12] Raw count pair reads high byte then low
// [RULE13] Status bit one means sensor touched
// [RULE14] Lock register bit 0 reports lock state
// [RULE15] Baseline, difference, raw pairs packed consecutively
`timescale 1ns/1ns
`include "tbr_map.svh"

module tbr_regs
  import tbr_pkg::*;
(
  input  wire logic             I_CLOCK,
  input  wire logic             I_NRST,
  input  wire tbr_req_t         I_REQ,
  input  wire logic             I_ADDR_LOCKED,
  input  wire logic [1:0]       I_TOUCH_PINS,
  input  wire logic [1:0]       I_SENSOR_ON,
  input  wire tbr_result_t      I_RESULT_BTN1,
  input  wire tbr_result_t      I_RESULT_BTN2,
  output logic [7:0]            O_RDATA,
  output logic [6:0]            O_SLAVE_ADDR,
  output logic                  O_PULLUP_DISABLE
);

  logic        lock_prev_q;
  logic [6:0]  pend_addr_q;
  logic        pend_pud_q;
  logic        read_en_q;
  logic [1:0]  sel_mask_q;
  logic [1:0]  status_q;
  logic [7:0]  rdata_d;
  logic        lock_rise;
  logic        wr_addr;
  logic        wr_sel;
  logic        mask_ok;
  tbr_result_t sel_res;

  assign lock_rise = I_ADDR_LOCKED && !lock_prev_q;
  assign wr_addr   = I_REQ.wr && (I_REQ.addr == `TBR_OFS_ADDR_DRIVE);
  assign wr_sel    = I_REQ.wr && (I_REQ.addr == `TBR_OFS_SELECT);
  // One-hot and naming a pin configured for touch sensing
  assign mask_ok   = ((I_REQ.wdata[1:0] == 2'h1) || (I_REQ.wdata[1:0] == 2'h2)) // RULE8
                     && ((I_REQ.wdata[1:0] & ~I_TOUCH_PINS) == 2'h0);            // RULE6

  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST) begin
      lock_prev_q <= 1'h1;
    end else begin
      lock_prev_q <= I_ADDR_LOCKED;
    end
  end

  // Pending copy is writable only while unlocked
  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST) begin
      pend_addr_q <= `TBR_RST_SLAVE_ADDR;
      pend_pud_q  <= `TBR_RST_PULLUP_DIS;
    end else if (wr_addr && !I_ADDR_LOCKED) begin // RULE1
      pend_addr_q <= I_REQ.wdata[6:0]; // RULE4
      pend_pud_q  <= I_REQ.wdata[`TBR_BIT_PULLUP_DIS]; // RULE3
    end
  end

  // Applying only on relock keeps the address steady mid-transaction
  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST) begin
      O_SLAVE_ADDR     <= `TBR_RST_SLAVE_ADDR;
      O_PULLUP_DISABLE <= `TBR_RST_PULLUP_DIS;
    end else if (lock_rise) begin // RULE2
      O_SLAVE_ADDR     <= pend_addr_q;
      O_PULLUP_DISABLE <= pend_pud_q;
    end
  end

  // Whole write is dropped when the mask is bad, enable bit included
  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST) begin
      read_en_q  <= `TBR_RST_READ_EN;
      sel_mask_q <= `TBR_RST_SEL_MASK;
    end else if (wr_sel && mask_ok) begin // RULE8
      read_en_q  <= I_REQ.wdata[`TBR_BIT_READ_EN]; // RULE7
      sel_mask_q <= I_REQ.wdata[1:0];
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST) begin
      status_q <= `TBR_RST_STATUS;
    end else begin
      status_q <= I_SENSOR_ON; // RULE13
    end
  end

  always_comb begin
    sel_res = '0;
    if (read_en_q) begin // RULE7
      unique case (sel_mask_q)
        2'h1:    sel_res = I_RESULT_BTN1; // RULE9
        2'h2:    sel_res = I_RESULT_BTN2; // RULE9
        default: sel_res = '0;
      endcase
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    unique case (I_REQ.addr)
      `TBR_OFS_LOCK:       rdata_d = {7'h00, I_ADDR_LOCKED}; // RULE14
      `TBR_OFS_ADDR_DRIVE: rdata_d = {pend_pud_q, pend_addr_q};
      `TBR_OFS_SELECT:     rdata_d = {read_en_q, 5'h00, sel_mask_q};
      `TBR_OFS_BASE_HI:    rdata_d = sel_res.baseline_value[15:8]; // RULE10
      `TBR_OFS_BASE_LO:    rdata_d = sel_res.baseline_value[7:0]; // RULE10
      `TBR_OFS_DIFF_HI:    rdata_d = sel_res.difference_count[15:8]; // RULE11
      `TBR_OFS_DIFF_LO:    rdata_d = sel_res.difference_count[7:0]; // RULE11
      `TBR_OFS_RAW_HI:     rdata_d = sel_res.raw_count[15:8]; // RULE12
      `TBR_OFS_RAW_LO:     rdata_d = sel_res.raw_count[7:0]; // RULE12
      `TBR_OFS_STATUS:     rdata_d = {6'h00, status_q}; // RULE13
      default:             rdata_d = 8'h00;
    endcase
  end

  // Result bytes are live; a host wanting a coherent pair should read both quickly
  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST) begin
      O_RDATA <= 8'h00;
    end else if (I_REQ.rd) begin // RULE5 RULE15
      O_RDATA <= rdata_d;
    end
  end

  locked_wr_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE1
    (wr_addr && I_ADDR_LOCKED) |=> $stable(pend_addr_q) && $stable(pend_pud_q))
    else $error("address written while locked");

  relock_apply_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE2
    lock_rise |=> (O_SLAVE_ADDR == $past(pend_addr_q)))
    else $error("address not applied on relock");

  addr_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE2
    !lock_rise |=> $stable(O_SLAVE_ADDR) && $stable(O_PULLUP_DISABLE))
    else $error("address changed without relock");

  drive_apply_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE3
    (wr_addr && !I_ADDR_LOCKED) ##1 (I_ADDR_LOCKED && !lock_prev_q)
    |=> (O_PULLUP_DISABLE == $past(I_REQ.wdata[7], 2)))
    else $error("drive bit not applied");

  pin_select_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE6
    (wr_sel && ((I_REQ.wdata[1:0] & ~I_TOUCH_PINS) != 2'h0)) |=> $stable(sel_mask_q))
    else $error("non-touch pin selected");

  onehot_mask_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE8
    (wr_sel && !$onehot(I_REQ.wdata[1:0])) |=> $stable(sel_mask_q) && $stable(read_en_q))
    else $error("bad mask accepted");

  read_gate_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE7
    (I_REQ.rd && !read_en_q && (I_REQ.addr == `TBR_OFS_RAW_LO)) |=> (O_RDATA == 8'h00))
    else $error("result read while disabled");

  base_read_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE10
    (I_REQ.rd && read_en_q && (sel_mask_q == 2'h2) && (I_REQ.addr == `TBR_OFS_BASE_HI))
    |=> (O_RDATA == $past(I_RESULT_BTN2.baseline_value[15:8])))
    else $error("baseline high byte wrong");

  status_read_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE13
    (I_REQ.rd && (I_REQ.addr == `TBR_OFS_STATUS)) |=> (O_RDATA == {6'h00, $past(I_SENSOR_ON, 2)}))
    else $error("status byte wrong");

  // Reference copies rebuilt from the request stream, lock and touch-pin inputs alone, for the checks below
  logic [7:0] ref_sel_q;
  logic [7:0] ref_pend_q;
  logic [7:0] ref_applied_q;
  logic       ref_lock_q;

  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST) begin
      ref_sel_q <= 8'h00;
    end else if (wr_sel && (I_REQ.wdata[1:0] inside {2'h1, 2'h2}) && ((I_REQ.wdata[1:0] & I_TOUCH_PINS) != 2'h0)) begin
      ref_sel_q <= {I_REQ.wdata[`TBR_BIT_READ_EN], 5'h00, I_REQ.wdata[1:0]};
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST) begin
      ref_pend_q <= 8'h00;
    end else if (wr_addr && !I_ADDR_LOCKED) begin
      ref_pend_q <= I_REQ.wdata;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST) begin
      ref_lock_q    <= 1'h1;
      ref_applied_q <= 8'h00;
    end else begin
      ref_lock_q <= I_ADDR_LOCKED;
      if (I_ADDR_LOCKED && !ref_lock_q) begin
        ref_applied_q <= ref_pend_q;
      end
    end
  end

  sel_model_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE8
    ({read_en_q, 5'h00, sel_mask_q} == ref_sel_q))
    else $error("select register differs from reference");

  pend_model_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE1
    ({pend_pud_q, pend_addr_q} == ref_pend_q))
    else $error("pending copy differs from reference");

  applied_model_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE2
    ({O_PULLUP_DISABLE, O_SLAVE_ADDR} == ref_applied_q))
    else $error("applied address differs from reference");

  // Pending and applied address
  // A relock one idle cycle after the write must still carry the new drive bit
  drive_late_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE3
    (wr_addr && !I_ADDR_LOCKED) ##1 !wr_addr ##1 lock_rise
    |=> (O_PULLUP_DISABLE == $past(I_REQ.wdata[`TBR_BIT_PULLUP_DIS], 3)))
    else $error("drive bit lost after idle cycle");

  pend_addr_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE4
    (wr_addr && !I_ADDR_LOCKED) |=> (pend_addr_q == $past(I_REQ.wdata[6:0])))
    else $error("pending address not captured");

  pend_drive_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE3
    (wr_addr && !I_ADDR_LOCKED) |=> (pend_pud_q == $past(I_REQ.wdata[`TBR_BIT_PULLUP_DIS])))
    else $error("pending drive bit not captured");

  pend_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE1
    !wr_addr |=> $stable(pend_addr_q) && $stable(pend_pud_q))
    else $error("pending copy changed without write");

  relock_drive_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE2
    lock_rise |=> (O_PULLUP_DISABLE == $past(pend_pud_q)))
    else $error("drive bit not applied on relock");

  lock_read_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE14
    (I_REQ.rd && (I_REQ.addr == `TBR_OFS_LOCK)) |=> (O_RDATA == {7'h00, $past(I_ADDR_LOCKED)}))
    else $error("lock state byte wrong");

  pend_read_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE2
    (I_REQ.rd && (I_REQ.addr == `TBR_OFS_ADDR_DRIVE))
    |=> (O_RDATA == {$past(pend_pud_q), $past(pend_addr_q)}))
    else $error("pending readback wrong");

  // Readout select
  select_read_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE7
    (I_REQ.rd && (I_REQ.addr == `TBR_OFS_SELECT))
    |=> (O_RDATA == {$past(read_en_q), 5'h00, $past(sel_mask_q)}))
    else $error("select readback wrong");

  mask_take_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE8
    (wr_sel && $onehot(I_REQ.wdata[1:0]) && ((I_REQ.wdata[1:0] & ~I_TOUCH_PINS) == 2'h0))
    |=> (sel_mask_q == $past(I_REQ.wdata[1:0])) && (read_en_q == $past(I_REQ.wdata[`TBR_BIT_READ_EN])))
    else $error("valid mask not taken");

  sel_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE6
    !wr_sel |=> $stable(sel_mask_q) && $stable(read_en_q))
    else $error("selection changed without write");

  mask_legal_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE9
    (sel_mask_q != 2'h0) |-> $onehot(sel_mask_q))
    else $error("selection mask not one-hot");

  enable_mask_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE7
    read_en_q |-> $onehot(sel_mask_q))
    else $error("reading enabled without a selection");

  // Result bytes
  base_high1_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE10
    (I_REQ.rd && read_en_q && (sel_mask_q == 2'h1) && (I_REQ.addr == `TBR_OFS_BASE_HI))
    |=> (O_RDATA == $past(I_RESULT_BTN1.baseline_value[15:8])))
    else $error("button 1 baseline high byte wrong");

  base_low_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE10
    (I_REQ.rd && read_en_q && (sel_mask_q == 2'h1) && (I_REQ.addr == `TBR_OFS_BASE_LO))
    |=> (O_RDATA == $past(I_RESULT_BTN1.baseline_value[7:0])))
    else $error("button 1 baseline low byte wrong");

  base_low2_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE10
    (I_REQ.rd && read_en_q && (sel_mask_q == 2'h2) && (I_REQ.addr == `TBR_OFS_BASE_LO))
    |=> (O_RDATA == $past(I_RESULT_BTN2.baseline_value[7:0])))
    else $error("button 2 baseline low byte wrong");

  diff_high_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE11
    (I_REQ.rd && read_en_q && (sel_mask_q == 2'h1) && (I_REQ.addr == `TBR_OFS_DIFF_HI))
    |=> (O_RDATA == $past(I_RESULT_BTN1.difference_count[15:8])))
    else $error("difference high byte wrong");

  diff_low_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE11
    (I_REQ.rd && read_en_q && (sel_mask_q == 2'h2) && (I_REQ.addr == `TBR_OFS_DIFF_LO))
    |=> (O_RDATA == $past(I_RESULT_BTN2.difference_count[7:0])))
    else $error("difference low byte wrong");

  raw_high_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE12
    (I_REQ.rd && read_en_q && (sel_mask_q == 2'h1) && (I_REQ.addr == `TBR_OFS_RAW_HI))
    |=> (O_RDATA == $past(I_RESULT_BTN1.raw_count[15:8])))
    else $error("raw count high byte wrong");

  raw_low_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE12
    (I_REQ.rd && read_en_q && (sel_mask_q == 2'h2) && (I_REQ.addr == `TBR_OFS_RAW_LO))
    |=> (O_RDATA == $past(I_RESULT_BTN2.raw_count[7:0])))
    else $error("raw count low byte wrong");

  result_gate_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE5
    (I_REQ.rd && !read_en_q && (I_REQ.addr inside {[`TBR_OFS_BASE_HI:`TBR_OFS_RAW_LO]}))
    |=> (O_RDATA == 8'h00))
    else $error("result byte shown while reading disabled");

  unmapped_zero_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE15
    (I_REQ.rd && !(I_REQ.addr inside {`TBR_OFS_LOCK, `TBR_OFS_ADDR_DRIVE, [`TBR_OFS_SELECT:`TBR_OFS_STATUS]}))
    |=> (O_RDATA == 8'h00))
    else $error("unmapped offset read nonzero");

  rdata_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE5
    !I_REQ.rd |=> $stable(O_RDATA))
    else $error("read data changed without read");

  status_track_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST) // RULE13
    1'h1 |=> (status_q == $past(I_SENSOR_ON)))
    else $error("status not following sensing core");

  relock_c: cover property (@(posedge I_CLOCK) disable iff (!I_NRST)
    (wr_addr && !I_ADDR_LOCKED) ##[1:20] lock_rise);

  select_c: cover property (@(posedge I_CLOCK) disable iff (!I_NRST)
    (wr_sel && mask_ok && I_REQ.wdata[7]) ##1 (I_REQ.rd && I_REQ.addr == `TBR_OFS_DIFF_HI));

  reject_c: cover property (@(posedge I_CLOCK) disable iff (!I_NRST)
    wr_sel && !mask_ok);

  lock_read_c: cover property (@(posedge I_CLOCK) disable iff (!I_NRST)
    I_REQ.rd && (I_REQ.addr == `TBR_OFS_LOCK) && I_ADDR_LOCKED);

  btn2_read_c: cover property (@(posedge I_CLOCK) disable iff (!I_NRST)
    I_REQ.rd && read_en_q && (sel_mask_q == 2'h2) && (I_REQ.addr == `TBR_OFS_RAW_HI));

endmodule // tbr_regs

// [tb/tbr_host.sv]
// Purpose: host side model issuing byte register requests and steering the address lock
// Assumes: one request per access, read data sampled one cycle after the request edge
// Notes:   lock starts set, as after power-on
`timescale 1ns/1ns
module tbr_host
  import tbr_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic [7:0] i_rdata,
  output tbr_req_t        o_req,
  output logic            o_locked
);
  initial begin
    o_req = '0;
    o_locked = 1'b1;
  end
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge i_clock);
    o_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge i_clock);
    o_req <= '0;
    #1 q = i_rdata;
  endtask
  task automatic set_lock(input logic l);
    @(posedge i_clock);
    o_locked <= l;
  endtask
endmodule // tbr_host

// [tb/tbr_regs_tb_top.sv]
// Purpose: self-checking bench of the touch button readout bank
// Assumes: host model drives requests and lock
// Notes:   results and touch pins are randomised per select write
`timescale 1ns/1ns
`include "tbr_map.svh"
module tbr_regs_tb_top;
  import tbr_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        locked;
  logic [1:0]  touch = 2'h3;
  logic [1:0]  son = 2'h0;
  tbr_result_t r1 = '0;
  tbr_result_t r2 = '0;
  tbr_req_t    req;
  logic [7:0]  rdata, q, v, sel;
  logic [6:0]  sa;
  logic        pd;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          seed;
  tbr_host i_tbr_host (.i_clock(clk), .i_rdata(rdata), .o_req(req), .o_locked(locked));
  tbr_regs i_tbr_regs (.I_CLOCK(clk), .I_NRST(nrst), .I_REQ(req), .I_ADDR_LOCKED(locked), .I_TOUCH_PINS(touch),
    .I_SENSOR_ON(son), .I_RESULT_BTN1(r1), .I_RESULT_BTN2(r2), .O_RDATA(rdata), .O_SLAVE_ADDR(sa),
    .O_PULLUP_DISABLE(pd));
  initial forever #5 clk = ~clk;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // Byte k of the selected result, baseline first, high byte first
  function automatic logic [7:0] exp_res(input logic [7:0] s, input logic [7:0] a);
    logic [47:0] r;
    r = (s == 8'h81) ? r1 : (s == 8'h82) ? r2 : 48'h0;
    return (a == 8'h88) ? {6'h00, son} : 8'(r >> (8 * (8'h87 - a)));
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    conclude();
  end
  initial begin
    seed = $urandom(32'h6fd4);
    sel = 8'h00;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1 chk("drive_and_addr", 8'h00, {pd, sa});
    i_tbr_host.access(1'b0, `TBR_OFS_SELECT, 8'h00, q);
    chk("select", 8'h00, q);
    i_tbr_host.access(1'b0, `TBR_OFS_STATUS, 8'h00, q);
    chk("status", 8'h00, q);
    i_tbr_host.access(1'b0, 8'h80, 8'h00, q);
    chk("unmapped", 8'h00, q);
    $display("test reset done");
    v = 8'($urandom) | 8'h80;
    i_tbr_host.access(1'b1, `TBR_OFS_ADDR_DRIVE, v, q);
    i_tbr_host.access(1'b0, `TBR_OFS_ADDR_DRIVE, 8'h00, q);
    chk("locked_write", 8'h00, q);
    i_tbr_host.access(1'b0, `TBR_OFS_LOCK, 8'h00, q);
    chk("lock_locked", 8'h01, q);
    i_tbr_host.set_lock(1'b0);
    i_tbr_host.access(1'b0, `TBR_OFS_LOCK, 8'h00, q);
    chk("lock_open", 8'h00, q);
    i_tbr_host.access(1'b1, `TBR_OFS_ADDR_DRIVE, v, q);
    i_tbr_host.access(1'b0, `TBR_OFS_ADDR_DRIVE, 8'h00, q);
    chk("pending_readback", v, q);
    repeat (3) @(posedge clk);
    #1 chk("pending", 8'h00, {pd, sa});
    i_tbr_host.set_lock(1'b1);
    repeat (2) @(posedge clk);
    #1 chk("applied", v, {pd, sa});
    v = 8'($urandom) & 8'h7F;
    i_tbr_host.set_lock(1'b0);
    i_tbr_host.access(1'b1, `TBR_OFS_ADDR_DRIVE, v, q);
    i_tbr_host.set_lock(1'b1);
    repeat (2) @(posedge clk);
    #1 chk("reapplied", v, {pd, sa});
    $display("test address done");
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      touch <= 2'($urandom);
      son <= 2'($urandom);
      r1 <= 48'({$urandom, $urandom});
      r2 <= 48'({$urandom, $urandom});
      v = 8'($urandom) | {i[0], 7'h00};
      i_tbr_host.access(1'b1, `TBR_OFS_SELECT, v, q);
      if (v[1:0] inside {2'h1, 2'h2} && (v[1:0] & touch) != 2'h0) sel = {v[7], 5'h00, v[1:0]};
      i_tbr_host.access(1'b0, `TBR_OFS_SELECT, 8'h00, q);
      chk("select", sel, q);
      for (int a = 8'h82; a <= 8'h88; a++) begin
        i_tbr_host.access(1'b0, 8'(a), 8'h00, q);
        chk("result", exp_res(sel, 8'(a)), q);
      end
    end
    $display("test select done");
    conclude();
  end
endmodule // tbr_regs_tb_top
